// file: ccr_heat_ramp.sv
// thermal ramp limiting the active charge current code
`timescale 1ns/100ps
module ccr_heat_ramp (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] die_temp,
  input  wire logic [15:0] heat_begin,
  input  wire logic [15:0] heat_finish,
  input  wire logic [4:0]  target,
  output logic             engaged,
  output logic [4:0]       code
);
  // largest k with k*span <= 31*remaining; a comparator bank, no divider
  function automatic logic [4:0] ccr_ramp(input logic signed [16:0] sp,
                                          input logic signed [16:0] rm);
    logic [4:0]         r;
    logic signed [22:0] lim;
    r   = 5'h00;
    lim = 23'(rm) * 23'sd31;
    for (int k = 1; k < 32; k++) begin
      if (23'(sp) * 23'(k) <= lim) begin
        r = 5'(k);
      end
    end
    return r;
  endfunction

  localparam logic [4:0] THERM_RST = ccr_pkg::THERM_FULL;

  logic signed [16:0] span;
  logic signed [16:0] rem;
  logic               hot;
  logic [4:0]         cap;
  logic [4:0]         code_nxt;

  assign span = $signed({heat_finish[15], heat_finish}) - $signed({heat_begin[15], heat_begin});
  assign rem  = $signed({heat_finish[15], heat_finish}) - $signed({die_temp[15], die_temp});
  assign hot  = $signed(die_temp) > $signed(heat_begin);
  // a finish at or below begin leaves no ramp: cut straight to zero
  assign cap  = (span <= 17'sd0 || rem <= 17'sd0) ? 5'h00 : ccr_ramp(span, rem);
  assign code_nxt = (hot && cap < target) ? cap : target;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      engaged <= 1'b0;
      code    <= THERM_RST;
    end else begin
      engaged <= hot;
      code    <= code_nxt;
    end
  end
endmodule

// file: ccr_host.sv
// two-wire host model issuing word writes and reads
`timescale 1ns/100ps
module ccr_host #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input  wire logic mclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  // 8 mclk per step: scl high for 8, low for 16, above the 6 the port needs
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw();
    repeat (8) @(posedge mclk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    hw();
    scl <= 1'b1;
    hw();
    s = sda_in;
    scl <= 1'b0;
    hw();
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    hw();
    scl <= 1'b1;
    hw();
    sda_drv <= 1'b0;
    hw();
    scl <= 1'b0;
    hw();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    hw();
    scl <= 1'b1;
    hw();
    sda_drv <= 1'b1;
    hw();
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
  // low byte first, high byte second
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] v,
                    output logic ok);
    logic k0, k1, k2, k3;
    start();
    byte_tx({a, 1'b0}, k0);
    byte_tx(c, k1);
    byte_tx(v[7:0], k2);
    byte_tx(v[15:8], k3);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic       k;
    logic [7:0] lo, hi;
    start();
    byte_tx({ADDR, 1'b0}, k);
    byte_tx(c, k);
    start();
    byte_tx({ADDR, 1'b1}, k);
    byte_rx(1'b0, lo);
    byte_rx(1'b1, hi);
    stop();
    v = {hi, lo};
  endtask
endmodule

// file: ccr_pkg.sv
// constants and types for the charger configuration register bank
// Function
// - heat finish register, signed, resets to 125C code
// - thermal ramp caps charge code 31 to 0
// - halt bit 5 suspends charging while set
// - bit 4 starts resistance measurement when charging
// - bit 3 selects 11ms or 5s measurement interval when not charging
// - bit 2 keeps measurement running on battery
// - bit 1 runs power-point seek on droop level
// - bit 0 queues balance phase after absorb
// - balance request self clears: cap, halt, reset
// - host writing zero cancels balance phase
// - input current cap six bits, resets 63
// - input cap only reduces charge current
// - droop level eight bits, resets to 31
// - seek overrides droop; active level readable
// - storage arm sixteen bits, armed by 21325
// - armed storage engages once input below 1V
// - charge target five bits, resets to 31
// - active code follows target unless heat-limited
// - heat begin register resets to 120C code
// - absorb ends when elapsed seconds reach cap
// - balance phase ends when elapsed reaches cap
package ccr_pkg;
  localparam logic [7:0]  CMD_HEAT_BEGIN   = 8'h10;
  localparam logic [7:0]  CMD_HEAT_FINISH  = 8'h11;
  localparam logic [7:0]  CMD_SYS_CFG      = 8'h14;
  localparam logic [7:0]  CMD_IN_CAP       = 8'h15;
  localparam logic [7:0]  CMD_DROOP        = 8'h16;
  localparam logic [7:0]  CMD_STORE_ARM    = 8'h19;
  localparam logic [7:0]  CMD_CHG_TGT      = 8'h1a;
  localparam logic [7:0]  CMD_CHG_ACTIVE   = 8'h1e;
  localparam logic [7:0]  CMD_DROOP_ACTIVE = 8'h1f;

  localparam logic [15:0] RST_HEAT_BEGIN   = 16'h45e9;
  localparam logic [15:0] RST_HEAT_FINISH  = 16'h46d2;
  localparam logic [5:0]  RST_SYS_CFG      = 6'h00;
  localparam logic [5:0]  RST_IN_CAP       = 6'h3f;
  localparam logic [7:0]  RST_DROOP        = 8'h1f;
  localparam logic [15:0] RST_STORE_ARM    = 16'h0000;
  localparam logic [4:0]  RST_CHG_TGT      = 5'h1f;
  localparam logic [15:0] STORE_ARM_CODE   = 16'h534d;

  localparam int          BIT_HALT         = 5;
  localparam int          BIT_BSR          = 4;
  localparam int          BIT_RATE         = 3;
  localparam int          BIT_MEAS_ON      = 2;
  localparam int          BIT_SEEK         = 1;
  localparam int          BIT_BAL          = 0;
  localparam logic [4:0]  THERM_FULL       = 5'h1f;

  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          SEC_NS           = 1000000000;
  localparam int          FAST_MEAS_NS     = 11000000;
  localparam int          SEC_CYC          = SEC_NS / CLK_PERIOD_NS;
  localparam int          FAST_MEAS_CYC    = FAST_MEAS_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  SLOW_MEAS_S      = 3'h5;
  localparam logic [15:0] ABSORB_CAP_S     = 16'h1518;
  localparam logic [15:0] BAL_CAP_S        = 16'h0e10;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_CMD, I2C_CACK,
    I2C_WDAT, I2C_WACK, I2C_RDAT, I2C_RACK
  } ccr_i2c_e;
endpackage

// file: ccr_sec_timer.sv
// phase timer counting one-second ticks up to a cap
`timescale 1ns/100ps
module ccr_sec_timer (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tick,
  ccr_tmr_if.tmr    t
);
  logic [15:0] cnt_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
    end else if (t.clear) begin
      cnt_r <= 16'h0000;
    end else if (t.run && tick && !t.done) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // holds at cap so done stays up until cleared
  assign t.done = (cnt_r >= t.cap);
endmodule

// file: ccr_tmr_if.sv
// elapsed-seconds timer carrier between top and timer
`timescale 1ns/100ps
interface ccr_tmr_if;
  logic        run;
  logic        clear;
  logic [15:0] cap;
  logic        done;
  modport ctl (output run, output clear, output cap, input done);
  modport tmr (input run, input clear, input cap, output done);
endinterface

// file: ccr_top.sv
// charger configuration register bank behind the two-wire port
`timescale 1ns/100ps
module ccr_top #(
  parameter logic [6:0] DEV_ADDR      = 7'h5a,
  parameter int         SEC_CYC       = ccr_pkg::SEC_CYC,
  parameter int         FAST_MEAS_CYC = ccr_pkg::FAST_MEAS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [15:0] die_temp,
  input  wire logic        charging_active,
  input  wire logic        input_present,
  input  wire logic        in_absorb,
  input  wire logic        ibat_below_cx,
  input  wire logic        vin_low_in,
  input  wire logic [7:0]  mppt_droop,
  output logic             charge_halt,
  output logic [5:0]       input_cap_code,
  output logic [4:0]       charge_code_active,
  output logic             heat_limit_engaged,
  output logic [7:0]       droop_active,
  output logic             seek_run,
  output logic             meas_active,
  output logic             meas_strobe,
  output logic             bsr_start,
  output logic             absorb_end,
  output logic             bal_phase,
  output logic             storage_engage
);
  localparam int SEC_W  = $clog2(SEC_CYC);
  localparam int FAST_W = $clog2(FAST_MEAS_CYC);

  if (SEC_CYC < 2 || FAST_MEAS_CYC < 2) begin : g_bad_cycles
    $error("cycle counts must be at least 2");
  end

  // pin synchronisers: scl, sda, low-input comparator
  logic [2:0] pin_raw;
  logic [2:0] sy1_r;
  logic [2:0] sy2_r;
  logic [2:0] sy3_r;
  logic [2:0] flt_r;
  logic [2:0] flt_d_r;

  assign pin_raw = {vin_low_in, sda_in, scl_in};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        sy1_r[i]   <= (i < 2);
        sy2_r[i]   <= (i < 2);
        sy3_r[i]   <= (i < 2);
        flt_r[i]   <= (i < 2);
        flt_d_r[i] <= (i < 2);
      end else begin
        sy1_r[i]   <= pin_raw[i];
        sy2_r[i]   <= sy1_r[i];
        sy3_r[i]   <= sy2_r[i];
        if (sy2_r[i] == sy3_r[i]) begin
          flt_r[i] <= sy3_r[i];
        end
        flt_d_r[i] <= flt_r[i];
      end
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic sda_hi;
  logic bus_start;
  logic bus_stop;
  logic vin_low;

  assign sda_hi    = flt_r[1];
  assign vin_low   = flt_r[2];
  assign scl_rise  = flt_r[0] & ~flt_d_r[0];
  assign scl_fall  = ~flt_r[0] & flt_d_r[0];
  assign bus_start = flt_r[0] & flt_d_r[0] & flt_d_r[1] & ~sda_hi;
  assign bus_stop  = flt_r[0] & flt_d_r[0] & ~flt_d_r[1] & sda_hi;

  // registers
  logic [15:0] heat_begin_r;
  logic [15:0] heat_finish_r;
  logic [5:0]  cfg_r;
  logic [5:0]  in_cap_r;
  logic [7:0]  droop_r;
  logic [15:0] arm_r;
  logic [4:0]  chg_tgt_r;

  // two-wire slave
  ccr_pkg::ccr_i2c_e st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  tx_r;
  logic        rw_r;
  logic        hi_r;
  logic        nack_r;
  logic        drv_r;
  logic [7:0]  cmd_r;
  logic [7:0]  wlo_r;
  logic [15:0] rword_r;
  logic        wr_stb_r;
  logic [15:0] wr_data_r;
  logic [15:0] rd_val;

  // unmapped commands read zero, narrow registers zero-extend
  assign rd_val =
    (cmd_r == ccr_pkg::CMD_HEAT_BEGIN)   ? heat_begin_r :
    (cmd_r == ccr_pkg::CMD_HEAT_FINISH)  ? heat_finish_r :
    (cmd_r == ccr_pkg::CMD_SYS_CFG)      ? {10'h000, cfg_r} :
    (cmd_r == ccr_pkg::CMD_IN_CAP)       ? {10'h000, in_cap_r} :
    (cmd_r == ccr_pkg::CMD_DROOP)        ? {8'h00, droop_r} :
    (cmd_r == ccr_pkg::CMD_STORE_ARM)    ? arm_r :
    (cmd_r == ccr_pkg::CMD_CHG_TGT)      ? {11'h000, chg_tgt_r} :
    (cmd_r == ccr_pkg::CMD_CHG_ACTIVE)   ? {11'h000, charge_code_active} :
    (cmd_r == ccr_pkg::CMD_DROOP_ACTIVE) ? {8'h00, droop_active} : 16'h0000;

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drv_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r      <= ccr_pkg::I2C_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      hi_r      <= 1'b0;
      nack_r    <= 1'b1;
      drv_r     <= 1'b0;
      cmd_r     <= 8'h00;
      wlo_r     <= 8'h00;
      rword_r   <= 16'h0000;
      wr_stb_r  <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      if (bus_start) begin
        st_r  <= ccr_pkg::I2C_ADDR;
        cnt_r <= 4'h0;
        drv_r <= 1'b0;
      end else if (bus_stop) begin
        st_r  <= ccr_pkg::I2C_IDLE;
        drv_r <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == ccr_pkg::I2C_ADDR || st_r == ccr_pkg::I2C_CMD ||
            st_r == ccr_pkg::I2C_WDAT) begin
          sh_r  <= {sh_r[6:0], sda_hi};
          cnt_r <= cnt_r + 4'h1;
        end else if (st_r == ccr_pkg::I2C_RDAT) begin
          cnt_r <= cnt_r + 4'h1;
        end else if (st_r == ccr_pkg::I2C_RACK) begin
          nack_r <= sda_hi;
        end
      end else if (scl_fall) begin
        unique case (st_r)
          ccr_pkg::I2C_IDLE: begin
          end
          ccr_pkg::I2C_ADDR: begin
            if (cnt_r == 4'h8) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                st_r    <= ccr_pkg::I2C_AACK;
                drv_r   <= 1'b1;
                rw_r    <= sh_r[0];
                rword_r <= rd_val;
              end else begin
                st_r <= ccr_pkg::I2C_IDLE;
              end
            end
          end
          ccr_pkg::I2C_AACK: begin
            cnt_r <= 4'h0;
            hi_r  <= 1'b0;
            if (rw_r) begin
              st_r  <= ccr_pkg::I2C_RDAT;
              tx_r  <= rword_r[7:0];
              drv_r <= ~rword_r[7];
            end else begin
              st_r  <= ccr_pkg::I2C_CMD;
              drv_r <= 1'b0;
            end
          end
          ccr_pkg::I2C_CMD: begin
            if (cnt_r == 4'h8) begin
              cmd_r <= sh_r;
              st_r  <= ccr_pkg::I2C_CACK;
              drv_r <= 1'b1;
            end
          end
          ccr_pkg::I2C_CACK, ccr_pkg::I2C_WACK: begin
            st_r  <= ccr_pkg::I2C_WDAT;
            cnt_r <= 4'h0;
            drv_r <= 1'b0;
          end
          ccr_pkg::I2C_WDAT: begin
            if (cnt_r == 4'h8) begin
              // low byte first; the word commits only with its high byte
              if (!hi_r) begin
                wlo_r <= sh_r;
              end else begin
                wr_stb_r  <= 1'b1;
                wr_data_r <= {sh_r, wlo_r};
              end
              hi_r  <= ~hi_r;
              st_r  <= ccr_pkg::I2C_WACK;
              drv_r <= 1'b1;
            end
          end
          ccr_pkg::I2C_RDAT: begin
            if (cnt_r == 4'h8) begin
              st_r  <= ccr_pkg::I2C_RACK;
              hi_r  <= ~hi_r;
              drv_r <= 1'b0;
            end else begin
              tx_r  <= {tx_r[6:0], 1'b0};
              drv_r <= ~tx_r[6];
            end
          end
          ccr_pkg::I2C_RACK: begin
            cnt_r <= 4'h0;
            if (!nack_r) begin
              st_r  <= ccr_pkg::I2C_RDAT;
              tx_r  <= hi_r ? rword_r[15:8] : rword_r[7:0];
              drv_r <= hi_r ? ~rword_r[15] : ~rword_r[7];
            end else begin
              st_r <= ccr_pkg::I2C_IDLE;
            end
          end
        endcase
      end
    end
  end

  // write decode
  logic we_begin;
  logic we_finish;
  logic we_cfg;
  logic we_in_cap;
  logic we_droop;
  logic we_arm;
  logic we_tgt;

  assign we_begin  = wr_stb_r && cmd_r == ccr_pkg::CMD_HEAT_BEGIN;
  assign we_finish = wr_stb_r && cmd_r == ccr_pkg::CMD_HEAT_FINISH;
  assign we_cfg    = wr_stb_r && cmd_r == ccr_pkg::CMD_SYS_CFG;
  assign we_in_cap = wr_stb_r && cmd_r == ccr_pkg::CMD_IN_CAP;
  assign we_droop  = wr_stb_r && cmd_r == ccr_pkg::CMD_DROOP;
  assign we_arm    = wr_stb_r && cmd_r == ccr_pkg::CMD_STORE_ARM;
  assign we_tgt    = wr_stb_r && cmd_r == ccr_pkg::CMD_CHG_TGT;

  // phase timers and sequencing
  ccr_tmr_if abs_t ();
  ccr_tmr_if bal_t ();
  logic [SEC_W-1:0] sec_cnt_r;
  logic             sec_tick;
  logic             absorb_done;
  logic             absorb_done_d_r;
  logic             halt_nxt;
  logic             bal_nxt;

  assign sec_tick    = (sec_cnt_r == SEC_W'(SEC_CYC - 1));
  assign abs_t.run   = in_absorb && !charge_halt;
  assign abs_t.clear = !in_absorb;
  assign abs_t.cap   = ccr_pkg::ABSORB_CAP_S;
  assign absorb_done = in_absorb && (abs_t.done || ibat_below_cx);
  assign bal_t.run   = bal_phase;
  assign bal_t.clear = !bal_phase;
  assign bal_t.cap   = ccr_pkg::BAL_CAP_S;

  ccr_sec_timer u_abs_tmr (.mclk(mclk), .rst(rst), .tick(sec_tick), .t(abs_t));
  ccr_sec_timer u_bal_tmr (.mclk(mclk), .rst(rst), .tick(sec_tick), .t(bal_t));

  assign halt_nxt = we_cfg ? wr_data_r[ccr_pkg::BIT_HALT] : cfg_r[ccr_pkg::BIT_HALT];
  // self clear beats a host write landing in the same cycle
  assign bal_nxt  = (halt_nxt || bal_t.done) ? 1'b0 :
                    we_cfg ? wr_data_r[ccr_pkg::BIT_BAL] : cfg_r[ccr_pkg::BIT_BAL];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      heat_begin_r  <= ccr_pkg::RST_HEAT_BEGIN;
      heat_finish_r <= ccr_pkg::RST_HEAT_FINISH;
      cfg_r         <= ccr_pkg::RST_SYS_CFG;
      in_cap_r      <= ccr_pkg::RST_IN_CAP;
      droop_r       <= ccr_pkg::RST_DROOP;
      arm_r         <= ccr_pkg::RST_STORE_ARM;
      chg_tgt_r     <= ccr_pkg::RST_CHG_TGT;
    end else begin
      if (we_begin)  heat_begin_r  <= wr_data_r;
      if (we_finish) heat_finish_r <= wr_data_r;
      if (we_cfg)    cfg_r[5:1]    <= wr_data_r[5:1];
      cfg_r[ccr_pkg::BIT_BAL] <= bal_nxt;
      if (we_in_cap) in_cap_r      <= wr_data_r[5:0];
      if (we_droop)  droop_r       <= wr_data_r[7:0];
      if (we_arm)    arm_r         <= wr_data_r;
      if (we_tgt)    chg_tgt_r     <= wr_data_r[4:0];
    end
  end

  assign charge_halt    = cfg_r[ccr_pkg::BIT_HALT];
  assign seek_run       = cfg_r[ccr_pkg::BIT_SEEK];
  // feeds only the charge loop; system load current passes unchecked
  assign input_cap_code = in_cap_r;

  ccr_heat_ramp u_heat (
    .mclk        (mclk),
    .rst         (rst),
    .die_temp    (die_temp),
    .heat_begin  (heat_begin_r),
    .heat_finish (heat_finish_r),
    .target      (chg_tgt_r),
    .engaged     (heat_limit_engaged),
    .code        (charge_code_active)
  );

  // measurement pacing
  logic [FAST_W-1:0] fast_cnt_r;
  logic [2:0]        slow_cnt_r;
  logic              meas_on;
  logic              meas_fast;
  logic              bsr_pend_r;

  assign meas_on   = cfg_r[ccr_pkg::BIT_MEAS_ON] || input_present;
  assign meas_fast = cfg_r[ccr_pkg::BIT_RATE] || charging_active;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sec_cnt_r       <= '0;
      fast_cnt_r      <= '0;
      slow_cnt_r      <= 3'h0;
      meas_active     <= 1'b0;
      meas_strobe     <= 1'b0;
      bsr_pend_r      <= 1'b0;
      bsr_start       <= 1'b0;
      absorb_done_d_r <= 1'b0;
      absorb_end      <= 1'b0;
      bal_phase       <= 1'b0;
      droop_active    <= ccr_pkg::RST_DROOP;
      storage_engage  <= 1'b0;
    end else begin
      sec_cnt_r   <= sec_tick ? '0 : sec_cnt_r + 1'b1;
      meas_active <= meas_on;
      if (!meas_on || fast_cnt_r == FAST_W'(FAST_MEAS_CYC - 1)) begin
        fast_cnt_r <= '0;
      end else begin
        fast_cnt_r <= fast_cnt_r + 1'b1;
      end
      if (!meas_on || (sec_tick && slow_cnt_r == ccr_pkg::SLOW_MEAS_S - 3'h1)) begin
        slow_cnt_r <= 3'h0;
      end else if (sec_tick) begin
        slow_cnt_r <= slow_cnt_r + 3'h1;
      end
      meas_strobe <= meas_on && (meas_fast ? fast_cnt_r == FAST_W'(FAST_MEAS_CYC - 1) :
                     (sec_tick && slow_cnt_r == ccr_pkg::SLOW_MEAS_S - 3'h1));
      // a fresh request beats the firing that retires the old one
      bsr_pend_r <= (we_cfg && wr_data_r[ccr_pkg::BIT_BSR]) ||
                    (bsr_pend_r && !charging_active);
      bsr_start  <= bsr_pend_r && charging_active;
      absorb_done_d_r <= absorb_done;
      absorb_end      <= absorb_done && !absorb_done_d_r;
      if (!bal_nxt || charge_halt || bal_t.done) begin
        bal_phase <= 1'b0;
      end else if (absorb_done && cfg_r[ccr_pkg::BIT_BAL]) begin
        bal_phase <= 1'b1;
      end
      droop_active <= cfg_r[ccr_pkg::BIT_SEEK] ? mppt_droop : droop_r;
      // stays engaged once the input has dropped while armed
      if (arm_r == ccr_pkg::STORE_ARM_CODE && vin_low) begin
        storage_engage <= 1'b1;
      end
    end
  end
endmodule

// file: ccr_top_chk.sv
// port assertions for the charger register bank
`timescale 1ns/100ps
module ccr_top_chk #(
  parameter logic [6:0] DEV_ADDR      = 7'h5a,
  parameter int         SEC_CYC       = 100000000,
  parameter int         FAST_MEAS_CYC = 1100000
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic [15:0] die_temp,
  input wire logic        charging_active,
  input wire logic        input_present,
  input wire logic        in_absorb,
  input wire logic        ibat_below_cx,
  input wire logic        vin_low_in,
  input wire logic [7:0]  mppt_droop,
  input wire logic        charge_halt,
  input wire logic [5:0]  input_cap_code,
  input wire logic [4:0]  charge_code_active,
  input wire logic        heat_limit_engaged,
  input wire logic [7:0]  droop_active,
  input wire logic        seek_run,
  input wire logic        meas_active,
  input wire logic        meas_strobe,
  input wire logic        bsr_start,
  input wire logic        absorb_end,
  input wire logic        bal_phase,
  input wire logic        storage_engage
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_halt_no_bal: assert property (charge_halt |=> !bal_phase)
    else $error("balance phase running while halted");
  a_bal_start_ok: assert property ($rose(bal_phase) |-> !$past(charge_halt))
    else $error("balance phase started while halted");
  a_seek_droop: assert property (seek_run && $past(seek_run) |-> droop_active == $past(mppt_droop))
    else $error("active droop not following seek value");
  a_meas_input: assert property (input_present |=> meas_active)
    else $error("measurement off with input present");
  a_strobe_pulse: assert property (meas_strobe |=> !meas_strobe)
    else $error("measurement strobe longer than one cycle");
  a_bsr_charging: assert property (bsr_start |-> $past(charging_active) ##1 !bsr_start)
    else $error("resistance start without charge cycle");
  a_absorb_cause: assert property (absorb_end |-> $past(in_absorb) || $past(in_absorb, 2))
    else $error("absorb end outside absorb phase");
  a_storage_hold: assert property (storage_engage |=> storage_engage)
    else $error("storage mode dropped before reset");
endmodule
bind ccr_top ccr_top_chk #(.DEV_ADDR(DEV_ADDR), .SEC_CYC(SEC_CYC), .FAST_MEAS_CYC(FAST_MEAS_CYC))
  i_ccr_top_chk (.*);

// file: ccr_top_test.sv
// self-checking bench for the charger register bank
`timescale 1ns/100ps
module ccr_top_test;
  logic        mclk, rst, scl, hsda, sda, sda_out, sda_oe_n, ok;
  logic        charging_active, input_present, in_absorb, ibat_below_cx, vin_low_in;
  logic        charge_halt, heat_limit_engaged, seek_run, meas_active, meas_strobe;
  logic        bsr_start, absorb_end, bal_phase, storage_engage;
  logic [15:0] die_temp, v;
  logic [7:0]  mppt_droop, droop_active;
  logic [5:0]  input_cap_code;
  logic [4:0]  charge_code_active;
  int          err_count, n_checks, k;
  localparam logic [7:0]  CMD [7] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h19, 8'h1a};
  localparam logic [15:0] RSV [7] = '{16'h45e9, 16'h46d2, 0, 16'h3f, 16'h1f, 0, 16'h1f};
  localparam logic [15:0] MSK [7] = '{16'hffff, 16'hffff, 16'h3f, 16'h3f, 16'hff, 16'hffff, 16'h1f};
  // open-drain line with pull-up
  assign sda = hsda & (sda_oe_n | sda_out);
  ccr_host i_ccr_host (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_drv(hsda));
  ccr_top #(.SEC_CYC(10), .FAST_MEAS_CYC(8)) i_ccr_top (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .die_temp(die_temp), .charging_active(charging_active),
    .input_present(input_present), .in_absorb(in_absorb), .ibat_below_cx(ibat_below_cx),
    .vin_low_in(vin_low_in), .mppt_droop(mppt_droop), .charge_halt(charge_halt),
    .input_cap_code(input_cap_code), .charge_code_active(charge_code_active),
    .heat_limit_engaged(heat_limit_engaged), .droop_active(droop_active),
    .seek_run(seek_run), .meas_active(meas_active), .meas_strobe(meas_strobe),
    .bsr_start(bsr_start), .absorb_end(absorb_end), .bal_phase(bal_phase),
    .storage_engage(storage_engage));
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rr(input logic [7:0] c, input logic [15:0] e);
    i_ccr_host.rd(c, v);
    chk($sformatf("cmd %h", c), v, e);
  endtask
  task automatic ww(input logic [7:0] c, input logic [15:0] d);
    i_ccr_host.wr(7'h5a, c, d, ok);
    chk("write ack", ok, 1);
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wt(string n, ref logic s, input logic lv, input int lim);
    n_checks++;
    for (int i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (s === lv) return;
    end
    err_count++;
    $display("[FAIL] %s expected %b seen %b", n, lv, s);
    close_out();
  endtask
  task automatic strobes(output int n);
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      if (meas_strobe === 1'b1) n++;
    end
  endtask
  task automatic bal_go();
    ww(8'h14, 16'h0001);
    @(posedge mclk);
    in_absorb <= 1'b1;
    ibat_below_cx <= 1'b1;
    wt("absorb_end", absorb_end, 1'b1, 10);
    wt("bal_phase", bal_phase, 1'b1, 5);
    @(posedge mclk);
    in_absorb <= 1'b0;
    ibat_below_cx <= 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst, die_temp, charging_active, input_present, in_absorb} = {1'b1, 19'h0};
    {ibat_below_cx, vin_low_in, err_count, n_checks} = 0;
    mppt_droop = 8'h55;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    foreach (CMD[i]) rr(CMD[i], RSV[i]);
    rr(8'h1e, 16'h1f);
    chk("input_cap_code", input_cap_code, 16'h3f);
    // wide pattern, arm register gets a non-arming value with input low
    @(posedge mclk);
    vin_low_in <= 1'b1;
    foreach (CMD[i]) if (i != 2) ww(CMD[i], 16'hffaa);
    foreach (CMD[i]) if (i != 2) rr(CMD[i], 16'hffaa & MSK[i]);
    for (int i = 0; i < 2; i++) ww(CMD[i], RSV[i]);
    repeat (4) @(negedge mclk);
    chk("input_cap_code", input_cap_code, 16'h2a);
    chk("charge_code_active", charge_code_active, 16'h0a);
    chk("droop_active", droop_active, 16'haa);
    chk("storage_engage", storage_engage, 0);
    rr(8'h12, 0);
    i_ccr_host.wr(7'h21, 8'h15, 16'h0001, ok);
    chk("foreign ack", ok, 0);
    rr(8'h15, 16'h2a);
    ww(8'h14, 16'h0002);
    repeat (4) @(negedge mclk);
    chk("seek_run", seek_run, 1);
    chk("droop_active", droop_active, 16'h55);
    rr(8'h1f, 16'h55);
    rr(8'h16, 16'haa);
    ww(8'h14, 16'h000c);
    strobes(k);
    chk("meas_active", meas_active, 1);
    chk("fast strobes", k >= 4, 1);
    ww(8'h14, 16'h0004);
    strobes(k);
    chk("slow strobes", k <= 1, 1);
    ww(8'h14, 16'h0000);
    chk("meas_active", meas_active, 0);
    @(posedge mclk);
    input_present <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("meas_active", meas_active, 1);
    input_present <= 1'b0;
    // ramp midpoint: floor(31*117/233) = 15
    ww(8'h1a, 16'h001f);
    die_temp <= 16'd18013;
    repeat (4) @(negedge mclk);
    chk("heat_limit_engaged", heat_limit_engaged, 1);
    chk("charge_code_active", charge_code_active, 15);
    die_temp <= 16'd18130;
    repeat (4) @(negedge mclk);
    chk("charge_code_active", charge_code_active, 0);
    die_temp <= 16'd17897;
    repeat (4) @(negedge mclk);
    chk("heat_limit_engaged", heat_limit_engaged, 0);
    chk("charge_code_active", charge_code_active, 31);
    die_temp <= 16'h0;
    ww(8'h14, 16'h0010);
    k = 0;
    repeat (20) @(negedge mclk) if (bsr_start === 1'b1) k++;
    chk("early bsr", k, 0);
    charging_active <= 1'b1;
    wt("bsr_start", bsr_start, 1'b1, 10);
    charging_active <= 1'b0;
    bal_go();
    ww(8'h14, 16'h0000);
    wt("bal_phase", bal_phase, 1'b0, 10);
    bal_go();
    ww(8'h14, 16'h0021);
    wt("bal_phase", bal_phase, 1'b0, 10);
    chk("charge_halt", charge_halt, 1);
    rr(8'h14, 16'h0020);
    bal_go();
    wt("bal_phase", bal_phase, 1'b0, 40000);
    rr(8'h14, 16'h0000);
    ww(8'h19, 16'h534d);
    wt("storage_engage", storage_engage, 1'b1, 20);
    vin_low_in <= 1'b0;
    repeat (5) @(negedge mclk);
    chk("storage_engage", storage_engage, 1);
    close_out();
  end
endmodule
